// >>> logic/lcsf_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "lcsf_defines.svh"
module lcsf_top (
    input  wire logic                        sys_clk,
    input  wire logic                        nrst,
    // host register port
    input  wire logic [`LCSF_ADDR_W-1:0]     regAddr,
    input  wire logic                        regWrite,
    input  wire logic                        regRead,
    input  wire logic [`LCSF_DATA_W-1:0]     regWdata,
    output logic [`LCSF_DATA_W-1:0]          regRdata,
    // link receiver events and levels
    input  wire logic                        linkUp,
    input  wire logic                        decodeError,
    input  wire logic                        syncErrorFixed,
    input  wire logic                        checksumError,
    input  wire logic                        syncNoValidRcvd,
    input  wire logic                        rxOutputError,
    input  wire logic [`LCSF_FL_PIO_W-1:0]   pioIn,
    // fifo events and controls
    input  wire logic                        rxFifoOverflow,
    input  wire logic                        txFifoOverflow,
    output logic                             rxFifoHalt,
    output logic                             rxFifoErase,
    output logic                             txFifoErase,
    output logic                             sendSyncMarker,
    output logic [`LCSF_FL_PIO_W-1:0]        pioOut,
    // data path through the loopback switch
    input  wire logic [`LCSF_DATA_W-1:0]     linkRxData,
    input  wire logic                        linkRxValid,
    input  wire logic [`LCSF_DATA_W-1:0]     userTxData,
    input  wire logic                        userTxValid,
    output logic [`LCSF_DATA_W-1:0]          linkTxData,
    output logic                             linkTxValid,
    output logic [`LCSF_DATA_W-1:0]          userRxData,
    output logic                             userRxValid
);
    lcsf_pkg::lcsf_top_t state;
    lcsf_pkg::lcsf_top_t next_state;

    lcsf_flag_if flg [`LCSF_NUM_FLAGS] ();

    logic [`LCSF_ST_CNT_W-1:0] decodeErrorCount;
    logic                      wrControl;
    logic                      wrFlags;
    logic                      clrStatus;
    logic                      clrSync;
    logic                      clrRxErr;
    logic [`LCSF_DATA_W-1:0]   controlView;
    logic [`LCSF_DATA_W-1:0]   statusView;
    logic [`LCSF_DATA_W-1:0]   flagsView;

    assign wrControl = regWrite && (regAddr == `LCSF_OFS_CONTROL);
    assign wrFlags   = regWrite && (regAddr == `LCSF_OFS_FLAGS);

    // write-one actions: zero writes do nothing and the bits never store
    assign clrStatus = wrControl && regWdata[`LCSF_CTL_CLR_STATUS];
    assign clrSync   = wrControl && regWdata[`LCSF_CTL_CLR_SYNC];
    assign clrRxErr  = wrControl && regWdata[`LCSF_CTL_CLR_RXERR];

    genvar i;
    generate
        for (i = 0; i < `LCSF_NUM_FLAGS; i++) begin : gFlag
            lcsf_sticky uSticky (
                .sys_clk (sys_clk),
                .nrst    (nrst),
                .port    (flg[i])
            );
        end
    endgenerate

    // link drop: held set while the link stays down, even across a clear
    assign flg[`LCSF_FLG_LINK_DOWN].set   = !linkUp;
    assign flg[`LCSF_FLG_LINK_DOWN].clear = clrStatus;
    assign flg[`LCSF_FLG_SYNC_ERR].set    = syncErrorFixed;
    assign flg[`LCSF_FLG_SYNC_ERR].clear  = clrStatus;
    assign flg[`LCSF_FLG_CKSUM].set       = checksumError;
    assign flg[`LCSF_FLG_CKSUM].clear     = clrStatus;
    assign flg[`LCSF_FLG_RX_OVF].set      = rxFifoOverflow;
    assign flg[`LCSF_FLG_RX_OVF].clear    = clrStatus;
    assign flg[`LCSF_FLG_TX_OVF].set      = txFifoOverflow;
    assign flg[`LCSF_FLG_TX_OVF].clear    = clrStatus;

    // sync marker received: cleared by the clear-sync action only
    assign flg[`LCSF_FLG_SYNC_RCVD].set   = syncNoValidRcvd;
    assign flg[`LCSF_FLG_SYNC_RCVD].clear = clrSync;

    // halt causes, each released by its own write-one bit
    assign flg[`LCSF_FLG_HALT_SYNC].set   = state.stopOnSync && syncNoValidRcvd;
    assign flg[`LCSF_FLG_HALT_SYNC].clear = clrSync;
    assign flg[`LCSF_FLG_HALT_ERR].set    = state.stopOnErr && rxOutputError;
    assign flg[`LCSF_FLG_HALT_ERR].clear  = clrRxErr;

    lcsf_err_counter uDecodeCount (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .inc     (decodeError),
        .clear   (clrStatus),
        .count   (decodeErrorCount)
    );

    // read views: unlisted bits stay zero
    always_comb begin
        controlView = '0;
        controlView[`LCSF_CTL_STOP_SYNC] = state.stopOnSync;
        controlView[`LCSF_CTL_STOP_ERR]  = state.stopOnErr;
        controlView[`LCSF_CTL_LOOPBACK]  = state.loopback;
    end

    always_comb begin
        statusView = '0;
        statusView[`LCSF_ST_CNT_LSB +: `LCSF_ST_CNT_W] = decodeErrorCount;
        statusView[`LCSF_ST_LINK_DOWN] = flg[`LCSF_FLG_LINK_DOWN].flag;
        statusView[`LCSF_ST_LINK_UP]   = linkUp;
        statusView[`LCSF_ST_SYNC_ERR]  = flg[`LCSF_FLG_SYNC_ERR].flag;
        statusView[`LCSF_ST_CKSUM_ERR] = flg[`LCSF_FLG_CKSUM].flag;
        statusView[`LCSF_ST_RX_OVF]    = flg[`LCSF_FLG_RX_OVF].flag;
        statusView[`LCSF_ST_TX_OVF]    = flg[`LCSF_FLG_TX_OVF].flag;
    end

    always_comb begin
        flagsView = '0;
        flagsView[`LCSF_FL_PIO_OUT_LSB +: `LCSF_FL_PIO_W] = state.pioOut;
        flagsView[`LCSF_FL_SYNC_RCVD] = flg[`LCSF_FLG_SYNC_RCVD].flag;
        flagsView[`LCSF_FL_PIO_IN_LSB +: `LCSF_FL_PIO_W]  = pioIn;
    end

    always_comb begin
        next_state = state;
        next_state.txFifoErase = 1'b0;
        next_state.rxFifoErase = 1'b0;
        next_state.sendSync    = 1'b0;

        if (wrControl) begin
            next_state.stopOnSync  = regWdata[`LCSF_CTL_STOP_SYNC];
            next_state.stopOnErr   = regWdata[`LCSF_CTL_STOP_ERR];
            next_state.loopback    = regWdata[`LCSF_CTL_LOOPBACK];
            next_state.txFifoErase = regWdata[`LCSF_CTL_ERASE_TX];
            next_state.rxFifoErase = regWdata[`LCSF_CTL_ERASE_RX];
        end

        if (wrFlags) begin
            next_state.sendSync = regWdata[`LCSF_FL_SEND_SYNC];
            next_state.pioOut   = regWdata[`LCSF_FL_PIO_OUT_LSB +: `LCSF_FL_PIO_W];
        end

        // read data is captured a cycle after the strobe; unmapped reads zero
        if (regRead) begin
            unique case (regAddr)
                `LCSF_OFS_CONTROL: next_state.regRdata = controlView;
                `LCSF_OFS_STATUS:  next_state.regRdata = statusView;
                `LCSF_OFS_FLAGS:   next_state.regRdata = flagsView;
                default:           next_state.regRdata = '0;
            endcase
        end

        // loopback turns the link stream around inside; user side sees nothing
        if (state.loopback) begin
            next_state.linkTxData  = linkRxData;
            next_state.linkTxValid = linkRxValid;
            next_state.userRxData  = '0;
            next_state.userRxValid = 1'b0;
        end else begin
            next_state.linkTxData  = userTxData;
            next_state.linkTxValid = userTxValid;
            next_state.userRxData  = linkRxData;
            next_state.userRxValid = linkRxValid;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign regRdata       = state.regRdata;
    assign txFifoErase    = state.txFifoErase;
    assign rxFifoErase    = state.rxFifoErase;
    assign sendSyncMarker = state.sendSync;
    assign pioOut         = state.pioOut;
    assign rxFifoHalt     = flg[`LCSF_FLG_HALT_SYNC].flag || flg[`LCSF_FLG_HALT_ERR].flag;
    assign linkTxData     = state.linkTxData;
    assign linkTxValid    = state.linkTxValid;
    assign userRxData     = state.userRxData;
    assign userRxValid    = state.userRxValid;
endmodule : lcsf_top
`default_nettype wire

// >>> logic/lcsf_defines.svh
`ifndef LCSF_DEFINES_SVH
`define LCSF_DEFINES_SVH

`define LCSF_ADDR_W          8
`define LCSF_DATA_W          32
`define LCSF_OFS_CONTROL     8'h08
`define LCSF_OFS_STATUS      8'h0c
`define LCSF_OFS_FLAGS       8'h10

`define LCSF_CTL_STOP_SYNC   4
`define LCSF_CTL_STOP_ERR    5
`define LCSF_CTL_LOOPBACK    11
`define LCSF_CTL_CLR_STATUS  16
`define LCSF_CTL_CLR_SYNC    17
`define LCSF_CTL_CLR_RXERR   18
`define LCSF_CTL_ERASE_TX    19
`define LCSF_CTL_ERASE_RX    20

`define LCSF_ST_CNT_LSB      0
`define LCSF_ST_CNT_W        8
`define LCSF_ST_LINK_DOWN    8
`define LCSF_ST_LINK_UP      9
`define LCSF_ST_SYNC_ERR     10
`define LCSF_ST_CKSUM_ERR    11
`define LCSF_ST_RX_OVF       12
`define LCSF_ST_TX_OVF       13

`define LCSF_FL_SEND_SYNC    0
`define LCSF_FL_PIO_OUT_LSB  1
`define LCSF_FL_SYNC_RCVD    8
`define LCSF_FL_PIO_IN_LSB   9
`define LCSF_FL_PIO_W        4

`define LCSF_NUM_FLAGS       8
`define LCSF_FLG_LINK_DOWN   0
`define LCSF_FLG_SYNC_ERR    1
`define LCSF_FLG_CKSUM       2
`define LCSF_FLG_RX_OVF      3
`define LCSF_FLG_TX_OVF      4
`define LCSF_FLG_SYNC_RCVD   5
`define LCSF_FLG_HALT_SYNC   6
`define LCSF_FLG_HALT_ERR    7

`endif

// >>> logic/lcsf_pkg.sv
`default_nettype none
`include "lcsf_defines.svh"
package lcsf_pkg;

    typedef struct packed {
        logic flag;
    } lcsf_sticky_t;

    typedef struct packed {
        logic [`LCSF_ST_CNT_W-1:0] count;
    } lcsf_counter_t;

    typedef struct packed {
        logic                      loopback;
        logic                      stopOnSync;
        logic                      stopOnErr;
        logic [`LCSF_FL_PIO_W-1:0] pioOut;
        logic [`LCSF_DATA_W-1:0]   regRdata;
        logic                      txFifoErase;
        logic                      rxFifoErase;
        logic                      sendSync;
        logic [`LCSF_DATA_W-1:0]   linkTxData;
        logic                      linkTxValid;
        logic [`LCSF_DATA_W-1:0]   userRxData;
        logic                      userRxValid;
    } lcsf_top_t;

endpackage : lcsf_pkg
`default_nettype wire

// >>> logic/lcsf_flag_if.sv
`timescale 1ns/100ps
`default_nettype none
interface lcsf_flag_if;
    logic set;
    logic clear;
    logic flag;
    modport owner (input set, input clear, output flag);
    modport user  (output set, output clear, input flag);
endinterface : lcsf_flag_if
`default_nettype wire

// >>> logic/lcsf_sticky.sv
`timescale 1ns/100ps
`default_nettype none
`include "lcsf_defines.svh"
module lcsf_sticky (
    input  wire logic         sys_clk,
    input  wire logic         nrst,
    lcsf_flag_if.owner        port
);
    lcsf_pkg::lcsf_sticky_t state;
    lcsf_pkg::lcsf_sticky_t next_state;

    always_comb begin
        next_state = state;
        // a set arriving with the clear wins so the event is not lost
        if (port.set) begin
            next_state.flag = 1'b1;
        end else if (port.clear) begin
            next_state.flag = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign port.flag = state.flag;
endmodule : lcsf_sticky
`default_nettype wire

// >>> logic/lcsf_err_counter.sv
`timescale 1ns/100ps
`default_nettype none
`include "lcsf_defines.svh"
module lcsf_err_counter (
    input  wire logic                      sys_clk,
    input  wire logic                      nrst,
    input  wire logic                      inc,
    input  wire logic                      clear,
    output logic [`LCSF_ST_CNT_W-1:0]      count
);
    lcsf_pkg::lcsf_counter_t state;
    lcsf_pkg::lcsf_counter_t next_state;

    always_comb begin
        next_state = state;
        if (clear) begin
            // an error seen in the clearing cycle still counts
            next_state.count = inc ? `LCSF_ST_CNT_W'(1) : '0;
        end else if (inc && (state.count != '1)) begin
            next_state.count = state.count + `LCSF_ST_CNT_W'(1);
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign count = state.count;
endmodule : lcsf_err_counter
`default_nettype wire

// >>> sim/lcsf_top_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module lcsf_top_assertions (
    input wire logic        sys_clk,
    input wire logic        nrst,
    input wire logic [7:0]  regAddr,
    input wire logic        regWrite,
    input wire logic        regRead,
    input wire logic [31:0] regWdata,
    input wire logic [31:0] regRdata,
    input wire logic        linkUp,
    input wire logic [3:0]  pioIn,
    input wire logic        syncNoValidRcvd,
    input wire logic        rxOutputError,
    input wire logic        rxFifoHalt,
    input wire logic        rxFifoErase,
    input wire logic        txFifoErase,
    input wire logic        sendSyncMarker,
    input wire logic [3:0]  pioOut
);
    default clocking dclk @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);
    wire logic ctlWr = regWrite && regAddr == 8'h08;
    wire logic flgWr = regWrite && regAddr == 8'h10;
    wire logic stRd  = regRead && regAddr == 8'h0c;
    wire logic flgRd = regRead && regAddr == 8'h10;
    wire logic badRd = regRead && !(regAddr inside {8'h08, 8'h0c, 8'h10});
    rx_erase_a: assert property (ctlWr && regWdata[20] |=> rxFifoErase)
        else $error("rx erase pulse missing");
    rx_erase_quiet_a: assert property (!(ctlWr && regWdata[20]) |=> !rxFifoErase)
        else $error("rx erase without request");
    tx_erase_a: assert property (ctlWr && regWdata[19] |=> txFifoErase)
        else $error("tx erase pulse missing");
    sync_send_a: assert property (flgWr && regWdata[0] |=> sendSyncMarker)
        else $error("sync marker not sent");
    sync_quiet_a: assert property (!(flgWr && regWdata[0]) |=> !sendSyncMarker)
        else $error("sync marker without request");
    pio_out_a: assert property (flgWr |=> pioOut == $past(regWdata[4:1]))
        else $error("pio out level wrong");
    link_live_a: assert property (stRd |=> regRdata[9] == $past(linkUp))
        else $error("live link bit wrong");
    status_rsvd_a: assert property (stRd |=> regRdata[31:14] == 18'h0)
        else $error("status reserved bits set");
    flags_read_a: assert property (flgRd |=> regRdata[12:9] == $past(pioIn)
        && regRdata[31:13] == 19'h0 && regRdata[7:5] == 3'h0 && !regRdata[0])
        else $error("flags read wrong");
    unmapped_a: assert property (badRd |=> regRdata == 32'h0)
        else $error("unmapped read not zero");
    link_drop_a: assert property (!linkUp ##1 stRd |=> regRdata[8])
        else $error("link drop not latched");
    halt_release_a: assert property (ctlWr && regWdata[17] && regWdata[18]
        && !syncNoValidRcvd && !rxOutputError |=> !rxFifoHalt)
        else $error("halt not released");
    cover property (ctlWr && regWdata[20]);
    cover property (rxFifoHalt ##1 !rxFifoHalt);
    cover property (!linkUp ##1 stRd);
endmodule : lcsf_top_assertions
bind lcsf_top lcsf_top_assertions lcsf_top_assertions_inst (.sys_clk, .nrst, .regAddr,
    .regWrite, .regRead, .regWdata, .regRdata, .linkUp, .pioIn, .syncNoValidRcvd,
    .rxOutputError, .rxFifoHalt, .rxFifoErase, .txFifoErase, .sendSyncMarker, .pioOut);
`default_nettype wire

// >>> sim/link_control_status_flags_tb.sv
`timescale 1ns/100ps
`default_nettype none
module link_control_status_flags_tb;
    logic        sys_clk, nrst, regWrite, regRead, linkUp, decodeError, syncErrorFixed;
    logic        checksumError, syncNoValidRcvd, rxOutputError, rxFifoOverflow;
    logic        txFifoOverflow, linkRxValid, userTxValid, rxFifoHalt, rxFifoErase;
    logic        txFifoErase, sendSyncMarker, linkTxValid, userRxValid;
    logic [7:0]  regAddr;
    logic [3:0]  pioIn, pioOut;
    logic [31:0] regWdata, regRdata, linkRxData, userTxData, linkTxData, userRxData;
    int          bad_count = 0;
    int          tests_run = 0;

    lcsf_top lcsf_top_inst (.sys_clk, .nrst, .regAddr, .regWrite, .regRead, .regWdata,
        .regRdata, .linkUp, .decodeError, .syncErrorFixed, .checksumError, .syncNoValidRcvd,
        .rxOutputError, .pioIn, .rxFifoOverflow, .txFifoOverflow, .rxFifoHalt, .rxFifoErase,
        .txFifoErase, .sendSyncMarker, .pioOut, .linkRxData, .linkRxValid, .userTxData,
        .userTxValid, .linkTxData, .linkTxValid, .userRxData, .userRxValid);

    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : final_report

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : tick

    // called at a falling edge; returns one edge after the write was taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        regAddr = a;
        regWdata = d;
        regWrite = 1'b1;
        tick(1);
        regWrite = 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
        regAddr = a;
        regRead = 1'b1;
        tick(1);
        regRead = 1'b0;
        check(regRdata, exp, what);
    endtask : rd

    // hang guard: far beyond the real run length
    initial begin
        #200000;
        bad_count++;
        final_report();
    end

    initial begin
        {regWrite, regRead, decodeError, syncErrorFixed, checksumError} = '0;
        {syncNoValidRcvd, rxOutputError, rxFifoOverflow, txFifoOverflow} = '0;
        {linkRxValid, userTxValid, nrst} = '0;
        linkUp = 1'b1;
        regAddr = 8'h00;
        regWdata = 32'h0;
        pioIn = 4'h0;
        linkRxData = 32'h0;
        userTxData = 32'h0;
        tick(6);
        nrst = 1'b1;
        tick(1);
        // an idle edge between strobes so no pin is driven twice in one step
        rd(8'h08, 32'h0, "control reset");
        tick(1);
        rd(8'h0c, 32'h200, "status reset");
        tick(1);
        rd(8'h10, 32'h0, "flags reset");
        tick(1);
        rd(8'h04, 32'h0, "unmapped read");
        $display("test reset done");
        wr(8'h08, 32'hffffffff);
        check({rxFifoErase, txFifoErase}, 32'h3, "erase pulses");
        rd(8'h08, 32'h830, "control readback");
        check({rxFifoErase, txFifoErase}, 32'h0, "erase one cycle");
        wr(8'h08, 32'h0);
        check({rxFifoErase, txFifoErase}, 32'h0, "zero write no erase");
        tick(1);
        pioIn = 4'ha;
        wr(8'h10, 32'hffffffff);
        check({sendSyncMarker, pioOut}, 32'h1f, "sync and pio out");
        rd(8'h10, 32'h141e, "flags readback");
        wr(8'h10, 32'h0);
        check({sendSyncMarker, pioOut}, 32'h0, "flags zero write");
        $display("test control and flags done");
        {syncErrorFixed, checksumError, rxFifoOverflow, txFifoOverflow, decodeError} = '1;
        linkUp = 1'b0;
        tick(3);
        rd(8'h0c, 32'h3d03, "status while down");
        {syncErrorFixed, checksumError, rxFifoOverflow, txFifoOverflow, decodeError} = '0;
        linkUp = 1'b1;
        tick(1);
        rd(8'h0c, 32'h3f04, "status latched");
        wr(8'h08, 32'h10000);
        rd(8'h0c, 32'h200, "status cleared");
        decodeError = 1'b1;
        tick(260);
        decodeError = 1'b0;
        rd(8'h0c, 32'h2ff, "count saturates");
        wr(8'h08, 32'h10000);
        $display("test status done");
        syncNoValidRcvd = 1'b1;
        tick(1);
        syncNoValidRcvd = 1'b0;
        check(rxFifoHalt, 32'h0, "no halt when disabled");
        rd(8'h10, 32'h1500, "sync received");
        wr(8'h08, 32'h30);
        syncNoValidRcvd = 1'b1;
        tick(1);
        syncNoValidRcvd = 1'b0;
        check(rxFifoHalt, 32'h1, "halt on sync");
        wr(8'h08, 32'h20030);
        check(rxFifoHalt, 32'h0, "sync halt released");
        rd(8'h10, 32'h1400, "sync flag cleared");
        rxOutputError = 1'b1;
        tick(1);
        rxOutputError = 1'b0;
        check(rxFifoHalt, 32'h1, "halt on error");
        wr(8'h08, 32'h20030);
        check(rxFifoHalt, 32'h1, "error halt kept");
        tick(1);
        wr(8'h08, 32'h60030);
        check(rxFifoHalt, 32'h0, "error halt released");
        $display("test halt done");
        linkRxData = 32'h1234abcd;
        userTxData = 32'h5a5a0f0f;
        {linkRxValid, userTxValid} = 2'b11;
        tick(2);
        check(linkTxData, 32'h5a5a0f0f, "normal tx path");
        check(userRxData, 32'h1234abcd, "normal rx path");
        check(linkTxValid, 32'h1, "normal tx valid");
        check(userRxValid, 32'h1, "normal rx valid");
        wr(8'h08, 32'h800);
        tick(2);
        check(linkTxData, 32'h1234abcd, "looped tx path");
        check(userRxValid, 32'h0, "user rx quiet");
        check(userRxData, 32'h0, "user rx data quiet");
        check(linkTxValid, 32'h1, "looped tx valid");
        $display("test loopback done");
        final_report();
    end
endmodule : link_control_status_flags_tb
`default_nettype wire
